// >>> host_pins.sv
// Host model driving the direct input and low-power pins.
`timescale 1ns/10ps
`default_nettype none
module host_pins
#(parameter int IDLE_HOLD = 4)
(
   input  wire logic clk_i,
   input  wire logic a_i,
   input  wire logic b_i,
   input  wire logic idle_i,
   output logic      a_o,
   output logic      b_o,
   output logic      idle_o
);
   int unsigned hold_reg = 0;
   initial {a_o, b_o, idle_o} = 3'h1;
   always @(posedge clk_i)
   begin
      a_o <= a_i;
      b_o <= b_i;
      // A new low-power level is only taken once the old one has stood.
      if (idle_i != idle_o && hold_reg >= IDLE_HOLD)
      begin
         idle_o   <= idle_i;
         hold_reg <= 0;
      end
      else if (hold_reg < IDLE_HOLD)
         hold_reg <= hold_reg + 1;
   end
endmodule : host_pins
`default_nettype wire

// >>> input_map_mode_supply_control.sv
// Module: direct input mapping, mode selection and supply gating.
`timescale 1ns/10ps
`default_nettype none
//Function
// RULE1: Default map links input a to channel 2 and input b to channel 3.
// RULE2: Each input has its own writable channel map register.
// RULE3: Channel drive is OR of output bits, mapped PWM and mapped inputs.
// RULE4: Input levels are visible in a monitor, also in limp-home mode.
// RULE5: Any input high with idle low enters limp-home on default channels.
// RULE6: Idle low with all inputs low enters sleep mode.
// RULE7: Host holds each idle level for the mode transition time.
// RULE8: Idle low returns every register to its default value.
// RULE9: Sleep conditions disable both supply undervoltage detectors.
// RULE10: Sleep conditions refuse serial traffic and keep serial output off.
// RULE11: Both supplies low block channels and serial traffic, reset registers.
// RULE12: Digital supply low blocks serial traffic and resets registers.
// RULE13: Analog supply low disables channels until it recovers.
module input_map_mode_supply_control
   import supply_ctrl_pkg::*;
(
   input  wire logic                        CLK_I,
   input  wire logic                        RESET_I,
   input  wire logic                        CE_I,
   input  wire logic                        DIRECT_INPUT_A_I,
   input  wire logic                        DIRECT_INPUT_B_I,
   input  wire logic                        IDLE_I,
   input  wire logic                        ANALOG_SUPPLY_UV_I,
   input  wire logic                        DIGITAL_SUPPLY_UV_I,
   input  wire logic                        REG_WE_I,
   input  wire supply_ctrl_pkg::regs_t      REG_WDATA_I,
   input  wire logic [1:0]                  PWM_I,
   input  wire logic                        CHIP_SELECT_LOW_I,
   output var  supply_ctrl_pkg::regs_t      REG_RDATA_O,
   output var  logic [1:0]                  INPUT_LEVEL_MONITOR_O,
   output var  logic [7:0]                  CHANNEL_DRIVE_O,
   output var  supply_ctrl_pkg::mode_t      MODE_O,
   output logic                             SPI_ENABLE_O,
   output logic                             SERIAL_OUT_OE_O,
   output logic                             UV_DETECT_EN_O
);
   import supply_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic       in_a;
   logic       in_b;
   logic       idle;
   logic       uv_a;
   logic       uv_d;

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         // Reset to the resting pin levels so no false limp-home follows.
         sync1_reg <= 5'h04;
         sync2_reg <= 5'h04;
      end
      else if (CE_I)
      begin
         sync1_reg <= {DIGITAL_SUPPLY_UV_I, ANALOG_SUPPLY_UV_I, IDLE_I,
                       DIRECT_INPUT_B_I, DIRECT_INPUT_A_I};
         sync2_reg <= sync1_reg;
      end
   end

   assign in_a = sync2_reg[0];
   assign in_b = sync2_reg[1];
   assign idle = sync2_reg[2];
   // Detectors are off in sleep, so their flags count only when enabled.
   assign uv_a = sync2_reg[3] & UV_DETECT_EN_O;
   assign uv_d = sync2_reg[4] & UV_DETECT_EN_O;

   ////////////////////////////////////////////////////////////////////////
   // Mode selection.
   logic  sleep_cond;
   mode_t mode_next;

   assign sleep_cond = !idle && !in_a && !in_b;

   always_comb
   begin
      if (idle)
         mode_next = MODE_ACTIVE;
      else if (in_a || in_b)
         mode_next = MODE_LIMP;                        // [RULE5]
      else
         mode_next = MODE_SLEEP;                       // [RULE6]
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         MODE_O <= MODE_SLEEP;
      else if (CE_I)
         MODE_O <= mode_next;
   end

   assign UV_DETECT_EN_O = !sleep_cond;                // [RULE9]
   // Serial access needs idle high, no sleep and a good digital supply.
   assign SPI_ENABLE_O = idle && !sleep_cond && !uv_d; // [RULE10] [RULE11] [RULE12]
   assign SERIAL_OUT_OE_O = SPI_ENABLE_O && !CHIP_SELECT_LOW_I; // [RULE10]

   ////////////////////////////////////////////////////////////////////////
   // Register file with defaults forced by idle low or digital undervoltage.
   regs_t regs_reg;

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         regs_reg <= REGS_RST;
      else if (CE_I)
      begin
         if (!idle || uv_d)
            regs_reg <= REGS_RST;                      // [RULE1] [RULE8] [RULE11] [RULE12]
         else if (REG_WE_I && SPI_ENABLE_O)
            regs_reg <= REG_WDATA_I;                   // [RULE2]
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
      begin
         REG_RDATA_O           <= REGS_RST;
         INPUT_LEVEL_MONITOR_O <= 2'h0;
      end
      else if (CE_I)
      begin
         REG_RDATA_O           <= regs_reg;
         INPUT_LEVEL_MONITOR_O <= {in_b, in_a};        // [RULE4]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel drive.
   logic [7:0] drive_next;
   logic [7:0] map_a_use;
   logic [7:0] map_b_use;

   always_comb
   begin
      map_a_use = (MODE_O == MODE_LIMP) ? MAP_A_RST : regs_reg.map_a; // [RULE5]
      map_b_use = (MODE_O == MODE_LIMP) ? MAP_B_RST : regs_reg.map_b;
      drive_next = regs_reg.out_bits
                 | (regs_reg.pwm0_map & {N_CH{PWM_I[0]}})
                 | (regs_reg.pwm1_map & {N_CH{PWM_I[1]}})
                 | (map_a_use & {N_CH{in_a}})
                 | (map_b_use & {N_CH{in_b}});          // [RULE3]
      if (uv_a || MODE_O == MODE_SLEEP)
         drive_next = 8'h00;                           // [RULE11] [RULE13]
   end

   always_ff @(posedge CLK_I)
   begin
      if (RESET_I)
         CHANNEL_DRIVE_O <= 8'h00;
      else if (CE_I)
         CHANNEL_DRIVE_O <= drive_next;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   a_uv_kills_drive: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && uv_a |=> CHANNEL_DRIVE_O == 8'h00)      // [RULE13]
      else $error("Drive active during analog undervoltage.");
   a_sleep_no_spi: assert property (@(posedge CLK_I) disable iff (RESET_I)
      sleep_cond |-> !SERIAL_OUT_OE_O && !UV_DETECT_EN_O) // [RULE10]
      else $error("Serial output driven in sleep.");
   a_idle_resets_regs: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && !idle |=> regs_reg == REGS_RST)         // [RULE8]
      else $error("Registers not at default with idle low.");
   a_limp_entry: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && !idle && in_a |=> MODE_O == MODE_LIMP)  // [RULE5]
      else $error("Limp-home not entered.");
   a_limp_default_ch: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && MODE_O == MODE_LIMP && in_a && !uv_a |=> CHANNEL_DRIVE_O[2]) // [RULE5]
      else $error("Default channel of input a not driven in limp-home.");
   a_sleep_entry: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && sleep_cond |=> MODE_O == MODE_SLEEP)    // [RULE6]
      else $error("Sleep not entered.");
   a_dig_uv_block: assert property (@(posedge CLK_I) disable iff (RESET_I)
      uv_d |-> !SPI_ENABLE_O)                         // [RULE12]
      else $error("Serial access during digital undervoltage.");
   a_monitor_tracks: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I |=> INPUT_LEVEL_MONITOR_O == $past({in_b, in_a})) // [RULE4]
      else $error("Input monitor does not follow inputs.");
   a_or_drive: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && !uv_a && MODE_O != MODE_SLEEP |=>
      (CHANNEL_DRIVE_O & $past(regs_reg.out_bits)) == $past(regs_reg.out_bits)) // [RULE3]
      else $error("Output register bit not reflected in drive.");
   a_map_default: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && !idle |=> regs_reg.map_b == MAP_B_RST) // [RULE1]
      else $error("Input b map not at default.");
   a_map_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
      CE_I && REG_WE_I && SPI_ENABLE_O |=> regs_reg == $past(REG_WDATA_I)) // [RULE2]
      else $error("Map write not stored.");
   // Double undervoltage closes serial access at once and drive one edge on.
   sequence s_spi_closed;
      !SPI_ENABLE_O;
   endsequence
   sequence s_drive_off;
      CHANNEL_DRIVE_O == 8'h00;
   endsequence
   a_both_uv: assert property (@(posedge CLK_I) disable iff (RESET_I) // [RULE11]
      CE_I && uv_a && uv_d |-> s_spi_closed ##1 s_drive_off)
      else $error("Double undervoltage not blocking.");
   a_map_a_default: assert property (@(posedge CLK_I) // [RULE1]
      disable iff (RESET_I) CE_I && !idle |=> regs_reg.map_a == MAP_A_RST)
      else $error("Input a map not at default.");
   a_sleep_no_drive: assert property (@(posedge CLK_I) // [RULE6]
      disable iff (RESET_I)
      CE_I && MODE_O == MODE_SLEEP |=> CHANNEL_DRIVE_O == 8'h00)
      else $error("Drive active in sleep.");
   a_oe_needs_select: assert property (@(posedge CLK_I) // [RULE10]
      disable iff (RESET_I)
      SERIAL_OUT_OE_O |-> SPI_ENABLE_O && !CHIP_SELECT_LOW_I)
      else $error("Serial output driven without access.");
   a_detect_awake: assert property (@(posedge CLK_I) // [RULE9]
      disable iff (RESET_I) !sleep_cond |-> UV_DETECT_EN_O)
      else $error("Detectors off outside sleep.");
endmodule : input_map_mode_supply_control
`default_nettype wire

// >>> supply_ctrl_pkg.sv
// Package: constants and carrier types of the input map and supply control.
`default_nettype none
package supply_ctrl_pkg;
   localparam int N_CH          = 8;
   localparam int N_PWM         = 2;
   localparam logic [7:0] MAP_A_RST = 8'h04;
   localparam logic [7:0] MAP_B_RST = 8'h08;
   localparam logic [7:0] OUT_RST   = 8'h00;
   localparam logic [7:0] PWMMAP_RST = 8'h00;
   localparam logic [1:0] PWMEN_RST = 2'h0;

   typedef enum logic [2:0]
   {
      MODE_SLEEP  = 3'b001,
      MODE_ACTIVE = 3'b010,
      MODE_LIMP   = 3'b100
   } mode_t;

   typedef struct packed
   {
      logic [7:0] out_bits;
      logic [7:0] map_a;
      logic [7:0] map_b;
      logic [7:0] pwm0_map;
      logic [7:0] pwm1_map;
   } regs_t;

   localparam regs_t REGS_RST = '{OUT_RST, MAP_A_RST, MAP_B_RST,
                                  PWMMAP_RST, PWMMAP_RST};
endpackage : supply_ctrl_pkg
`default_nettype wire

// >>> test_input_map_mode_supply_control.sv
// Testbench for input mapping, modes and supply gating.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_input_map_mode_supply_control;
   import supply_ctrl_pkg::*;
   localparam logic [55:0] ALL = '1;
   logic clk = 0, rst = 1, we = 0, uva = 0, uvd = 0, spi, oe, uen;
   logic a = 0, b = 0, idle = 1, pa, pb, pidle;
   logic ce = 1, chip_select_low = 0;
   logic [1:0] pwm = 0, mon;
   logic [7:0] drv;
   regs_t wd = REGS_RST, rd;
   mode_t mode;
   int err_count = 0, n_checks = 0, step = 0;
   logic [55:0] q_exp[$], q_msk[$];
   event sample_ev;
   input_map_mode_supply_control input_map_mode_supply_control_input_level_monitor (
      .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .DIRECT_INPUT_A_I(pa),
      .DIRECT_INPUT_B_I(pb), .IDLE_I(pidle), .ANALOG_SUPPLY_UV_I(uva),
      .DIGITAL_SUPPLY_UV_I(uvd), .REG_WE_I(we), .REG_WDATA_I(wd),
      .PWM_I(pwm), .CHIP_SELECT_LOW_I(chip_select_low), .REG_RDATA_O(rd),
      .INPUT_LEVEL_MONITOR_O(mon), .CHANNEL_DRIVE_O(drv), .MODE_O(mode),
      .SPI_ENABLE_O(spi), .SERIAL_OUT_OE_O(oe), .UV_DETECT_EN_O(uen));
   host_pins host_pins_input_level_monitor (.clk_i(clk), .a_i(a), .b_i(b), .idle_i(idle),
      .a_o(pa), .b_o(pb), .idle_o(pidle));
   initial forever #12.5 clk = ~clk;
   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // The serial output is expected to drive only while chip_select_low is 0, not while chip select is low.
   task automatic expect_now(regs_t r, logic [7:0] d, mode_t m,
      logic [1:0] mv, logic s, logic u, logic [55:0] k);
      repeat (10) @(posedge clk);
      q_exp.push_back({r, d, m, mv, s, s & ~chip_select_low, u});
      q_msk.push_back(k);
      -> sample_ev;
   endtask : expect_now
   task automatic wr(regs_t v);
      @(posedge clk);
      we <= 1;
      wd <= v;
      @(posedge clk);
      we <= 0;
   endtask : wr
   task automatic pins(logic ia, logic ib, logic ii, logic [1:0] pw);
      @(posedge clk);
      a <= ia;
      b <= ib;
      idle <= ii;
      pwm <= pw;
   endtask : pins
   always @(sample_ev)
   begin
      logic [55:0] k;
      logic [55:0] x;
      k = q_msk.pop_front();
      x = q_exp.pop_front();
      @(negedge clk);
      `CHK({rd, drv, mode, mon, spi, oe, uen} & k, x & k)
      $display("step %0d done", ++step);
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      err_count++;
      finish_test();
   end
   initial
   begin
      regs_t r;
      logic [63:0] t;
      logic [1:0] p;
      logic [7:0] e;
      void'($urandom(3087));
      repeat (16) @(posedge clk);
      rst <= 0;
      expect_now(REGS_RST, 8'h00, MODE_ACTIVE, 2'h0, 1, 1, ALL);
      ce <= 0;
      pins(1, 0, 1, 0);
      expect_now(REGS_RST, 8'h00, MODE_ACTIVE, 2'h0, 1, 1, ALL);
      ce <= 1;
      expect_now(REGS_RST, 8'h04, MODE_ACTIVE, 2'h1, 1, 1, ALL);
      pins(0, 1, 1, 0);
      expect_now(REGS_RST, 8'h08, MODE_ACTIVE, 2'h2, 1, 1, ALL);
      for (int i = 0; i < 6; i++)
      begin
         t = {$urandom, $urandom};
         r = t[39:0];
         p = t[41:40];
         wr(r);
         pins(t[42], t[43], 1, p);
         chip_select_low <= t[44];
         e = r.out_bits | ({8{p[0]}} & r.pwm0_map) | ({8{p[1]}} & r.pwm1_map)
             | ({8{t[42]}} & r.map_a) | ({8{t[43]}} & r.map_b);
         expect_now(r, e, MODE_ACTIVE, t[43:42], 1, 1, ALL);
      end
      chip_select_low <= 0;
      pins(1, 0, 0, 0);
      expect_now(REGS_RST, 8'h04, MODE_LIMP, 2'h1, 0, 1, ALL);
      pins(1, 1, 0, 0);
      expect_now(REGS_RST, 8'h0C, MODE_LIMP, 2'h3, 0, 1, ALL);
      pins(0, 0, 0, 3);
      wr(r);
      expect_now(REGS_RST, 8'h00, MODE_SLEEP, 2'h0, 0, 0, ALL);
      uva <= 1;
      expect_now(REGS_RST, 8'h00, MODE_SLEEP, 2'h0, 0, 0, ALL);
      uva <= 0;
      pins(0, 0, 1, 0);
      repeat (4) @(posedge clk);
      wr(r);
      uvd <= 1;
      expect_now(REGS_RST, 8'h00, MODE_ACTIVE, 2'h0, 0, 1, ALL);
      uvd <= 0;
      repeat (3) @(posedge clk);
      wr(r);
      uva <= 1;
      expect_now(r, 8'h00, MODE_ACTIVE, 2'h0, 1, 1, ALL);
      uva <= 0;
      expect_now(r, r.out_bits, MODE_ACTIVE, 2'h0, 1, 1, ALL);
      uva <= 1;
      uvd <= 1;
      expect_now(REGS_RST, 8'h00, MODE_ACTIVE, 2'h0, 0, 1, ALL);
      repeat (2) @(posedge clk);
      finish_test();
   end
endmodule : test_input_map_mode_supply_control
`default_nettype wire
